// ==== hw/drc_integrity_flag.sv ====
// Active-low data-integrity flag: set by loss events, released by a completed update
`timescale 1ns/1ps
`include "drc_regs.svh"

module drc_integrity_flag (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Events
  input wire logic loss_evt,
  input wire logic update_done,
  // Flag
  output logic flag_n
);
  import drc_pkg::*;

  logic flag_n_r;
  logic flag_n_nxt;

  // Loss wins over release so an event in the release cycle is never missed
  always_comb begin
    flag_n_nxt = flag_n_r;
    if (loss_evt) begin
      flag_n_nxt = 1'h0;
    end else if (update_done) begin
      flag_n_nxt = 1'h1;
    end
  end

  // Flag register, asserted out of reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flag_n_r <= `DRC_FLAG_RST;
    end else begin
      flag_n_r <= flag_n_nxt;
    end
  end

  assign flag_n = flag_n_r;

  flag_loss_wins_a: assert property (@(posedge clock) disable iff (sys_rst)
    loss_evt && update_done |=> !flag_n)
    else $error("integrity flag released despite a loss event");

endmodule // drc_integrity_flag

// ==== hw/drc_pkg.sv ====
// Types shared by the DAC reset, clear and integrity-flag logic
`include "drc_regs.svh"

package drc_pkg;

  // One channel's span field
  typedef logic [`DRC_SPAN_W-1:0] drc_span_type;

  // Tracker of the instruction framed by the select/load strobe
  typedef enum logic [1:0] {
    DRC_IDLE = `DRC_ST_IDLE,
    DRC_ACTIVE = `DRC_ST_ACTIVE,
    DRC_ABORTED = `DRC_ST_ABORTED
  } drc_instr_type;

endpackage

// ==== hw/drc_regs.svh ====
// Reset values, field widths and counts for the DAC reset, clear and integrity-flag logic
`ifndef DRC_REGS_SVH
`define DRC_REGS_SVH

// Number of converter channels
`define DRC_NUM_CH 4
// Span field width and its power-up value (unipolar 0 V to 5 V)
`define DRC_SPAN_W 4
`define DRC_SPAN_RST 4'h0
// Code field width and its power-up value (zero volts)
`define DRC_CODE_W 16
`define DRC_CODE_RST 16'h0000
// Integrity flag level at power-up (asserted, low)
`define DRC_FLAG_RST 1'h0
// Instruction tracker state codes
`define DRC_ST_IDLE 2'h0
`define DRC_ST_ACTIVE 2'h1
`define DRC_ST_ABORTED 2'h2

`endif

// ==== hw/drc_reset_clear.sv ====
// Reset, system clear and update control of span and code registers for a quad DAC
// Function
// - Power-up puts every channel in the 0 V to 5 V unipolar span, span field all zeros.
// - Power-up clears every input and DAC register so each output starts at zero volts.
// - In manual span mode the strapped span is loaded with the code into each channel that the update selects.
// - A low clear input resets the active span and code registers of all channels to zero.
// - A system clear leaves input registers untouched so a later update restores them.
// - Clear during an instruction (strobe low) aborts it; its input writes are dropped.
// - The integrity flag goes low at power-up, on system clear, or on a supply dip.
// - The integrity flag stays low until a valid update completes, then goes high.
// - A low-going asynchronous update copies input code and span (strapped span in manual mode) into all DAC registers.
// - The asynchronous update is ignored unless the select/load strobe is high.
`timescale 1ns/1ps
`include "drc_regs.svh"

module drc_reset_clear #(
  parameter int NUM_CH = `DRC_NUM_CH,
  parameter int CODE_W = `DRC_CODE_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Power monitor
  input wire logic power_on_rst,
  input wire logic supply_dip,
  // Host pins
  input wire logic system_clear_n,
  input wire logic select_load_n,
  input wire logic async_update_n,
  // Span strapping
  input wire logic span_manual,
  input wire drc_pkg::drc_span_type span_select,
  // Input register writes from the serial decoder
  input wire logic in_wr_valid,
  input wire logic in_wr_is_span,
  input wire logic [NUM_CH-1:0] in_wr_mask,
  input wire logic [CODE_W-1:0] in_wr_data,
  // Update requests from the serial decoder
  input wire logic ser_update_valid,
  input wire logic [NUM_CH-1:0] ser_update_mask,
  // Register contents
  output drc_pkg::drc_span_type [NUM_CH-1:0] in_span,
  output logic [NUM_CH-1:0][CODE_W-1:0] in_code,
  output drc_pkg::drc_span_type [NUM_CH-1:0] dac_span,
  output logic [NUM_CH-1:0][CODE_W-1:0] dac_code,
  // Status
  output logic instr_aborted,
  output logic integrity_flag_n
);
  import drc_pkg::*;

  drc_instr_type state_r;
  drc_instr_type state_nxt;
  logic aborted_r;
  logic aborted_nxt;
  logic async_prev_r;
  logic async_prev_nxt;
  drc_span_type [NUM_CH-1:0] in_span_r;
  drc_span_type [NUM_CH-1:0] in_span_nxt;
  logic [NUM_CH-1:0][CODE_W-1:0] in_code_r;
  logic [NUM_CH-1:0][CODE_W-1:0] in_code_nxt;
  drc_span_type [NUM_CH-1:0] dac_span_r;
  drc_span_type [NUM_CH-1:0] dac_span_nxt;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_code_r;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_code_nxt;
  logic abort_now;
  logic wr_ok;
  logic async_take;
  logic [NUM_CH-1:0] upd_mask;
  logic upd_done;
  logic loss_evt;

  // Instruction may still act: no clear now and not killed earlier in the window
  function automatic logic instr_ok(input drc_instr_type st, input logic kill);
    return !kill && (st != DRC_ABORTED);
  endfunction

  // Clear landing inside a strobe-low window kills the instruction
  assign abort_now = !select_load_n && !system_clear_n;
  assign wr_ok = !select_load_n && instr_ok(state_r, abort_now);
  // Falling edge of the update pin counts only with the strobe high
  assign async_take = async_prev_r && !async_update_n && select_load_n;
  // Serial requests of an aborted instruction are dropped with its writes
  always_comb begin
    upd_mask = '0;
    if (ser_update_valid && instr_ok(state_r, abort_now)) begin
      upd_mask = ser_update_mask;
    end
    if (async_take) begin
      upd_mask = '1;
    end
  end
  // An update only completes while clear is released
  assign upd_done = (|upd_mask) && system_clear_n && !power_on_rst;
  assign loss_evt = power_on_rst || !system_clear_n || supply_dip;

  // Instruction tracker and edge memory of the update pin
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DRC_IDLE: begin
        if (!select_load_n) begin
          state_nxt = abort_now ? DRC_ABORTED : DRC_ACTIVE;
        end
      end
      DRC_ACTIVE: begin
        if (select_load_n) begin
          state_nxt = DRC_IDLE;
        end else if (abort_now) begin
          state_nxt = DRC_ABORTED;
        end
      end
      DRC_ABORTED: begin
        // Only the strobe going high ends a killed instruction
        if (select_load_n) begin
          state_nxt = DRC_IDLE;
        end
      end
      default: begin
        // Unused code, recover to idle
        state_nxt = DRC_IDLE;
      end
    endcase
    aborted_nxt = (state_nxt == DRC_ABORTED);
    async_prev_nxt = async_update_n;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= DRC_IDLE;
      aborted_r <= 1'h0;
      async_prev_r <= 1'h1;
    end else begin
      state_r <= state_nxt;
      aborted_r <= aborted_nxt;
      async_prev_r <= async_prev_nxt;
    end
  end

  // Input and DAC registers; a power-on event outranks everything else
  always_comb begin
    in_span_nxt = in_span_r;
    in_code_nxt = in_code_r;
    dac_span_nxt = dac_span_r;
    dac_code_nxt = dac_code_r;
    if (power_on_rst) begin
      in_span_nxt = {NUM_CH{`DRC_SPAN_RST}};
      in_code_nxt = {NUM_CH{`DRC_CODE_RST}};
      dac_span_nxt = {NUM_CH{`DRC_SPAN_RST}};
      dac_code_nxt = {NUM_CH{`DRC_CODE_RST}};
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        // Input registers are never touched by clear itself
        if (wr_ok && in_wr_valid && in_wr_mask[ch]) begin
          if (in_wr_is_span) begin
            in_span_nxt[ch] = in_wr_data[`DRC_SPAN_W-1:0];
          end else begin
            in_code_nxt[ch] = in_wr_data;
          end
        end
        if (!system_clear_n) begin
          // Held at zero for the whole low time, updates lose
          dac_span_nxt[ch] = `DRC_SPAN_RST;
          dac_code_nxt[ch] = `DRC_CODE_RST;
        end else if (upd_mask[ch]) begin
          // Strapped span rides along with the code in manual mode
          dac_span_nxt[ch] = span_manual ? span_select : in_span_r[ch];
          dac_code_nxt[ch] = in_code_r[ch];
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      in_span_r <= {NUM_CH{`DRC_SPAN_RST}};
      in_code_r <= {NUM_CH{`DRC_CODE_RST}};
      dac_span_r <= {NUM_CH{`DRC_SPAN_RST}};
      dac_code_r <= {NUM_CH{`DRC_CODE_RST}};
    end else begin
      in_span_r <= in_span_nxt;
      in_code_r <= in_code_nxt;
      dac_span_r <= dac_span_nxt;
      dac_code_r <= dac_code_nxt;
    end
  end

  // Flag tracking
  drc_integrity_flag u_flag (
    .clock(clock),
    .sys_rst(sys_rst),
    .loss_evt(loss_evt),
    .update_done(upd_done),
    .flag_n(integrity_flag_n)
  );

  // Outputs come straight from registers
  assign in_span = in_span_r;
  assign in_code = in_code_r;
  assign dac_span = dac_span_r;
  assign dac_code = dac_code_r;
  assign instr_aborted = aborted_r;

  // Checks
  default clocking drc_cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  por_span_zero_a: assert property (power_on_rst |=> (dac_span == '0) && (in_span == '0))
    else $error("span not zero after power-on");

  por_code_zero_a: assert property (power_on_rst |=> (dac_code == '0) && (in_code == '0))
    else $error("code not zero after power-on");

  manual_span_load_a: assert property (
    upd_mask[0] && span_manual && system_clear_n && !power_on_rst
    |=> dac_span[0] == $past(span_select))
    else $error("strapped span not loaded on update");

  clear_zero_a: assert property (!system_clear_n && !power_on_rst
    |=> (dac_span == '0) && (dac_code == '0))
    else $error("DAC registers not zero under clear");

  clear_hold_a: assert property (!system_clear_n [*3] |-> (dac_code == '0))
    else $error("DAC code moved while clear held low");

  clear_keeps_input_a: assert property (!system_clear_n && select_load_n && !power_on_rst
    |=> $stable(in_code) && $stable(in_span))
    else $error("input registers changed by clear");

  abort_drop_a: assert property (abort_now && !power_on_rst
    |=> instr_aborted && $stable(in_code) && $stable(in_span))
    else $error("aborted instruction still wrote input registers");

  flag_set_a: assert property (loss_evt |=> !integrity_flag_n)
    else $error("integrity flag not asserted after loss event");

  flag_release_a: assert property (!integrity_flag_n && upd_done && !loss_evt
    |=> integrity_flag_n)
    else $error("integrity flag not released after update");

  flag_hold_a: assert property (!integrity_flag_n && !upd_done |=> !integrity_flag_n)
    else $error("integrity flag released without update");

  async_all_a: assert property (async_take && system_clear_n && !power_on_rst
    |=> dac_code == $past(in_code))
    else $error("asynchronous update did not copy all codes");

  async_lock_a: assert property ($fell(async_update_n) && !select_load_n
    && !ser_update_valid && system_clear_n && !power_on_rst |=> $stable(dac_code))
    else $error("asynchronous update acted while strobe low");

  abort_seen_c: cover property (abort_now ##1 select_load_n);
  async_update_c: cover property (async_take && system_clear_n);
  flag_release_c: cover property (!integrity_flag_n ##1 integrity_flag_n);
  manual_span_c: cover property (upd_done && span_manual);

endmodule // drc_reset_clear

// ==== test/drc_host_model.sv ====
// Host controller model driving the clear, strobe, update and write pins
`timescale 1ns/1ps
module drc_host_model (
  // Clock
  input wire logic clock,
  // Host pins
  output logic system_clear_n,
  output logic select_load_n,
  output logic async_update_n,
  // Decoded instruction strobes
  output logic in_wr_valid,
  output logic in_wr_is_span,
  output logic [3:0] in_wr_mask,
  output logic [15:0] in_wr_data,
  output logic ser_update_valid,
  output logic [3:0] ser_update_mask
);
  // Idle levels; everything moves on falling edges only
  initial begin
    system_clear_n = 1'h1;
    select_load_n = 1'h1;
    async_update_n = 1'h1;
    in_wr_valid = 1'h0;
    in_wr_is_span = 1'h0;
    in_wr_mask = 4'h0;
    in_wr_data = 16'h5A5A;
    ser_update_valid = 1'h0;
    ser_update_mask = 4'h0;
  end
  // One write pulse; stale data inverted so it cannot pass for valid
  task automatic wr(input logic s, input logic [3:0] m, input logic [15:0] d);
    @(negedge clock);
    in_wr_valid = 1'h1;
    in_wr_is_span = s;
    in_wr_mask = m;
    in_wr_data = d;
    @(negedge clock);
    in_wr_valid = 1'h0;
    in_wr_data = ~d;
  endtask
  // One serial update pulse
  task automatic upd(input logic [3:0] m);
    @(negedge clock);
    ser_update_valid = 1'h1;
    ser_update_mask = m;
    @(negedge clock);
    ser_update_valid = 1'h0;
    ser_update_mask = ~m;
  endtask
  // Low-going update pin edge, one cycle low
  task automatic async_pulse();
    @(negedge clock);
    async_update_n = 1'h0;
    @(negedge clock);
    async_update_n = 1'h1;
  endtask
  // Level pins: 0 selects clear, otherwise the strobe
  task automatic pin(input int which, input logic v);
    @(negedge clock);
    if (which == 0) system_clear_n = v;
    else select_load_n = v;
  endtask
endmodule // drc_host_model

// ==== test/tb_top.sv ====
// Self-checking bench for the reset, clear and integrity-flag logic
`timescale 1ns/1ps
module tb_top;
  import drc_pkg::*;
  logic clock, sys_rst, power_on_rst, supply_dip, span_manual;
  drc_span_type span_select;
  logic system_clear_n, select_load_n, async_update_n, in_wr_valid, in_wr_is_span;
  logic ser_update_valid, instr_aborted, integrity_flag_n;
  logic [3:0] in_wr_mask, ser_update_mask;
  logic [15:0] in_wr_data;
  drc_span_type [3:0] in_span, dac_span;
  logic [3:0][15:0] in_code, dac_code;
  int n_fail = 0, cmp_count = 0, seed = 46043;
  int e_is[4], e_ic[4], e_ds[4], e_dc[4], e_flag, e_ab;

  drc_host_model host (.clock(clock), .system_clear_n(system_clear_n),
    .select_load_n(select_load_n), .async_update_n(async_update_n), .in_wr_valid(in_wr_valid),
    .in_wr_is_span(in_wr_is_span), .in_wr_mask(in_wr_mask), .in_wr_data(in_wr_data),
    .ser_update_valid(ser_update_valid), .ser_update_mask(ser_update_mask));
  drc_reset_clear #(.NUM_CH(4), .CODE_W(16)) dut (.clock(clock), .sys_rst(sys_rst),
    .power_on_rst(power_on_rst), .supply_dip(supply_dip), .system_clear_n(system_clear_n),
    .select_load_n(select_load_n), .async_update_n(async_update_n), .span_manual(span_manual),
    .span_select(span_select), .in_wr_valid(in_wr_valid), .in_wr_is_span(in_wr_is_span),
    .in_wr_mask(in_wr_mask), .in_wr_data(in_wr_data), .ser_update_valid(ser_update_valid),
    .ser_update_mask(ser_update_mask), .in_span(in_span), .in_code(in_code),
    .dac_span(dac_span), .dac_code(dac_code), .instr_aborted(instr_aborted),
    .integrity_flag_n(integrity_flag_n));

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input int e, input logic [15:0] g);
    cmp_count++;
    if (g !== e[15:0]) begin
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic chk_all();
    for (int i = 0; i < 4; i++) begin
      chk("in_span", e_is[i], {12'h0, in_span[i]});
      chk("in_code", e_ic[i], in_code[i]);
      chk("dac_span", e_ds[i], {12'h0, dac_span[i]});
      chk("dac_code", e_dc[i], dac_code[i]);
    end
    chk("flag", e_flag, {15'h0, integrity_flag_n});
    chk("aborted", e_ab, {15'h0, instr_aborted});
  endtask
  // Reference update: refused while clear is low or the instruction is aborted
  task automatic m_upd(input int m);
    if (system_clear_n === 1'h1 && e_ab == 0) begin
      for (int i = 0; i < 4; i++) begin
        if (m[i]) e_ds[i] = span_manual ? int'(span_select) : e_is[i];
        if (m[i]) e_dc[i] = e_ic[i];
      end
      // A supply dip in the same cycle keeps the flag low
      if (supply_dip !== 1'h1) e_flag = 1;
    end
  endtask
  task automatic do_wr(input int s, input int m, input int d);
    for (int i = 0; i < 4; i++) begin
      if (m[i] && select_load_n === 1'h0 && system_clear_n === 1'h1 && e_ab == 0) begin
        if (s != 0) e_is[i] = d & 15;
        else e_ic[i] = d & 16'hFFFF;
      end
    end
    host.wr(s[0], m[3:0], d[15:0]);
    chk_all();
  endtask
  task automatic do_upd(input int m);
    m_upd(m);
    host.upd(m[3:0]);
    chk_all();
  endtask
  task automatic do_async();
    if (select_load_n === 1'h1) m_upd(15);
    host.async_pulse();
    chk_all();
  endtask
  task automatic do_clear(input logic v);
    host.pin(0, v);
    @(negedge clock);
    if (!v) e_ds = '{0, 0, 0, 0};
    if (!v) e_dc = '{0, 0, 0, 0};
    if (!v) e_flag = 0;
    if (!v && select_load_n === 1'h0) e_ab = 1;
    chk_all();
  endtask
  task automatic do_sel(input logic v);
    host.pin(1, v);
    repeat (2) @(negedge clock);
    if (v) e_ab = 0;
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'h1;
    power_on_rst = 1'h0;
    supply_dip = 1'h0;
    span_manual = 1'h0;
    span_select = 4'h0;
    repeat (20) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'h0;
    chk_all();
    do_sel(1'h0);
    for (int k = 0; k < 8; k++) do_wr(k % 2, 1 << (k / 2), $random(seed));
    do_sel(1'h1);
    do_upd(15);
    for (int k = 0; k < 4; k++) do_upd(($random(seed) & 14) | 1);
    do_clear(1'h0);
    do_upd(15);
    do_async();
    do_clear(1'h1);
    do_async();
    do_sel(1'h0);
    do_wr(0, 15, $random(seed));
    do_async();
    do_sel(1'h1);
    do_async();
    do_sel(1'h0);
    do_clear(1'h0);
    do_wr(1, 15, 3);
    do_clear(1'h1);
    do_wr(0, 15, $random(seed));
    do_upd(15);
    do_sel(1'h1);
    do_sel(1'h0);
    do_wr(0, 5, $random(seed));
    do_sel(1'h1);
    do_upd(15);
    supply_dip = 1'h1;
    @(negedge clock);
    e_flag = 0;
    chk_all();
    // Update while the dip is still present: loss must win over release
    do_upd(2);
    supply_dip = 1'h0;
    do_upd(2);
    span_manual = 1'h1;
    for (int k = 0; k < 3; k++) begin
      span_select = 4'($random(seed));
      do_upd(15);
    end
    power_on_rst = 1'h1;
    @(negedge clock);
    power_on_rst = 1'h0;
    e_is = '{0, 0, 0, 0};
    e_ic = '{0, 0, 0, 0};
    e_ds = '{0, 0, 0, 0};
    e_dc = '{0, 0, 0, 0};
    e_flag = 0;
    chk_all();
    end_of_test();
  end
  // Watchdog well beyond the roughly 115 cycles of the sequence
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
endmodule // tb_top
